// ### dv/sbd_host_model.sv
// Behavioural serial master that stands in for the host controller.
// Assumes the bench calls xfer from one process, never two at once.
`timescale 1ns/1ps
`default_nettype none
module sbd_host_model (
    output logic spi_clk,
    output logic select_low,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    // Pull-ups hold clock and select high, the pull-down holds data low.
    initial begin
        spi_clk = 1'b1;
        select_low = 1'b1;
        mosi = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame
    // ------------------------------------------------------------
    // Shifts nbits of tx out, most significant first, and collects miso
    // on each rising clock edge; the clock stands still outside frames.
    task automatic xfer(input int nbits, input logic [39:0] tx,
                        output logic [39:0] rx);
        rx = '0;
        select_low = 1'b0;
        #200;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_clk = 1'b0;
            mosi = tx[i];
            #200;
            spi_clk = 1'b1;
            // A released line reads as the inverse, so a bit sampled
            // while the slave is not driving shows up as a mismatch.
            rx = {rx[38:0], miso_oe ? miso : ~miso};
            #200;
        end
        // Select rises with the clock high, then rests before a new frame.
        select_low = 1'b1;
        mosi = 1'b0;
        #600;
    endtask
endmodule
`default_nettype wire

// ### dv/tb_sbd_spi_bridge.sv
// Self-checking bench of the serial bridge with its host model.
// Assumes fault inputs are level signals in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module tb_sbd_spi_bridge;
    import sbd_pkg::*;
    logic clk, arst_n, spi_clk, select_low, mosi, miso, miso_oe;
    logic [7:0] status_flags, interrupt_status, oc_detect;
    logic sleep_mode, overtemp_evt, supply_fault;
    logic [4:0] fault_active, fault_flag;
    logic [3:0] open_short_flag, high_fet_on, low_fet_on;
    logic [39:0] rx; // Bits gathered by the host in the last frame.
    int n_mismatch = 0;
    int comparisons = 0;

    sbd_spi_bridge dut (.clk(clk), .arst_n(arst_n), .spi_clk(spi_clk),
        .select_low(select_low), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .status_flags(status_flags),
        .interrupt_status(interrupt_status), .sleep_mode(sleep_mode),
        .overtemp_evt(overtemp_evt), .supply_fault(supply_fault),
        .fault_active(fault_active), .fault_flag(fault_flag),
        .oc_detect(oc_detect), .open_short_flag(open_short_flag),
        .high_fet_on(high_fet_on), .low_fet_on(low_fet_on));
    sbd_host_model host (.spi_clk(spi_clk), .select_low(select_low),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

    // ------------------------------------------------------------
    // Clock, inputs at time zero and the hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Bit 4 of the flags is set so a status byte that copies it shows.
    initial begin
        arst_n = 1'b0;
        status_flags = 8'h5B;
        interrupt_status = 8'h3C;
        {sleep_mode, overtemp_evt, supply_fault} = 3'b000;
        {fault_active, fault_flag} = 10'h000;
        oc_detect = 8'h00;
        open_short_flag = 4'h9;
    end
    initial begin
        #2000000;
        n_mismatch++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Every input change lands 2 ns after a rising clock edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Gate outputs, checked once commit and gating have settled.
    task automatic gates(input logic [3:0] h, input logic [3:0] l);
        cyc(4);
        chk("high side", {4'h0, h}, {4'h0, high_fet_on});
        chk("low side", {4'h0, l}, {4'h0, low_fet_on});
    endtask
    // A write of n clocks; a short frame loses data bits at its tail.
    task automatic wr(input logic [4:0] a, input logic [7:0] d,
                      input int n = 16, input logic b = 1'b0);
        host.xfer(n, 40'({1'b0, a, b, 1'b0, d, 8'h00} >> (24 - n)), rx);
        cyc(6);
    endtask
    task automatic rd(input logic [4:0] a, input logic b, input int n);
        host.xfer(8 * (n + 1), 40'({1'b1, a, b, 1'b0}) << (8 * n), rx);
        cyc(2);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(5'h06, 1'b0, 1);
        chk("enable reset", 8'h00, rx[7:0]);
        chk("oe idle", 8'h00, {7'h0, miso_oe});
        rd(5'h0A, 1'b0, 1);
        chk("fault reset", 8'h90, rx[7:0]);
        gates(4'h0, 4'h0);
    endtask
    // Driver 0 has both enables set and must stay off.
    task automatic t_write();
        wr(5'h06, 8'h63);
        chk("status byte", 8'h4B, rx[15:8]);
        chk("pointer byte", 8'h3C, rx[7:0]);
        gates(4'h4, 4'h8);
        rd(5'h06, 1'b0, 3);
        chk("repeat read 0", 8'h63, rx[23:16]);
        chk("repeat read 1", 8'h63, rx[15:8]);
        chk("repeat read 2", 8'h63, rx[7:0]);
    endtask
    // A write with the burst bit set still lands as a plain write.
    task automatic t_frames();
        wr(5'h06, 8'h21, 16, 1'b1);
        rd(5'h06, 1'b0, 1);
        chk("burst bit write", 8'h21, rx[7:0]);
        wr(5'h06, 8'h63);
        wr(5'h06, 8'hFF, 17);
        wr(5'h06, 8'hFF, 15);
        rd(5'h06, 1'b0, 1);
        chk("bad length", 8'h63, rx[7:0]);
    endtask
    task automatic t_burst();
        wr(5'h05, 8'hA5);
        wr(5'h07, 8'h5A);
        rd(5'h05, 1'b1, 3);
        chk("burst 0", 8'hA5, rx[23:16]);
        chk("burst 1", 8'h63, rx[15:8]);
        chk("burst 2", 8'h5A, rx[7:0]);
        wr(5'h1F, 8'h07);
        rd(5'h1F, 1'b0, 1);
        chk("pointer", 8'h07, rx[7:0]);
        wr(5'h06, 8'h63);
        chk("moved pointer", 8'h5A, rx[7:0]);
    endtask
    // Over-current on the driver 2 high side, then a one-to-clear.
    task automatic t_overcurrent();
        oc_detect = 8'h20;
        cyc(1);
        oc_detect = 8'h00;
        gates(4'h0, 4'h8);
        rd(5'h0A, 1'b0, 1);
        chk("fault flags", 8'h94, rx[7:0]);
        wr(5'h0A, 8'hF4);
        chk("status oc", 8'h5B, rx[15:8]);
        gates(4'h4, 4'h8);
        rd(5'h0A, 1'b0, 1);
        chk("flag cleared", 8'h90, rx[7:0]);
    endtask
    task automatic t_safety();
        supply_fault = 1'b1;
        gates(4'h0, 4'h0);
        supply_fault = 1'b0;
        fault_active = 5'h04;
        gates(4'h4, 4'h8);
        fault_flag = 5'h04;
        gates(4'h0, 4'h0);
        {fault_active, fault_flag} = 10'h000;
        overtemp_evt = 1'b1;
        cyc(1);
        overtemp_evt = 1'b0;
        rd(5'h06, 1'b0, 1);
        chk("overtemp clear", 8'h00, rx[7:0]);
        wr(5'h06, 8'h63);
        sleep_mode = 1'b1;
        cyc(1);
        sleep_mode = 1'b0;
        rd(5'h06, 1'b0, 1);
        chk("sleep clear", 8'h00, rx[7:0]);
    endtask
    // A reset in mid-run clears the enables and returns the pointer.
    task automatic t_midreset();
        wr(5'h06, 8'h63);
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        cyc(3);
        gates(4'h0, 4'h0);
        rd(5'h06, 1'b0, 1);
        chk("enable after reset", 8'h00, rx[7:0]);
        wr(5'h06, 8'h00);
        chk("pointer after reset", 8'h3C, rx[7:0]);
    endtask

    // ------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #2;
        arst_n = 1'b1;
        cyc(3);
        t_reset();
        t_write();
        t_frames();
        t_burst();
        t_overcurrent();
        t_safety();
        t_midreset();
        end_sim();
    end
endmodule
`default_nettype wire

// ### src/sbd_mem_if.sv
// Interface between the serial bridge and its register store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sbd_mem_if #(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 8
);
    logic wr_en;                // One-cycle write strobe.
    logic [ADDR_W-1:0] wr_addr; // Write address.
    logic [DATA_W-1:0] wr_data; // Write data.
    logic [ADDR_W-1:0] rd_addr; // Read address, sampled every cycle.
    logic [DATA_W-1:0] rd_data; // Registered read data.

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data,
                   input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### src/sbd_pkg.sv
// Types shared by the serial bridge modules.
// Assumes no other package defines the same names.
package sbd_pkg;

    // Phase of the serial frame.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CMD,
        PH_DATA
    } sbd_phase_e;

endpackage

// ### src/sbd_reg_store.sv
// Generic register store of the serial bridge address space.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module sbd_reg_store #(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    sbd_mem_if.store bus
);
    // -----------------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------------
    // The array has no reset; software initialises what it uses.
    logic [DATA_W-1:0] mem_ff [2**ADDR_W];
    logic [DATA_W-1:0] rd_data_ff; // Registered read port.

    // Write port.
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem_ff[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Read port, registered so that timing does not depend on the array.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= mem_ff[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_data_ff;
endmodule
`default_nettype wire

// ### src/sbd_regs.svh
// Offsets, field positions, reset values and counts of the serial bridge.
// Assumes inclusion by bare name from the design files.
`ifndef SBD_REGS_SVH
`define SBD_REGS_SVH

// ---------------------------------------------------------------------------
// Widths and frame counts
// ---------------------------------------------------------------------------
`define SBD_ADDR_W 5
`define SBD_DATA_W 8
`define SBD_WR_CLOCKS 5'h10
`define SBD_CNT_SAT 5'h11

// ---------------------------------------------------------------------------
// Command byte fields
// ---------------------------------------------------------------------------
`define SBD_CMD_RW 7
`define SBD_CMD_AHI 6
`define SBD_CMD_ALO 2
`define SBD_CMD_BURST 1

// ---------------------------------------------------------------------------
// Register offsets and reset values
// ---------------------------------------------------------------------------
`define SBD_ADDR_IRQ 5'h01
`define SBD_ADDR_BRIDGE_EN 5'h06
`define SBD_ADDR_BRIDGE_ST 5'h0A
`define SBD_ADDR_PTR 5'h1F
`define SBD_RST_BRIDGE_EN 8'h00
`define SBD_RST_BRIDGE_ST 4'h0
`define SBD_RST_PTR `SBD_ADDR_IRQ

`endif

// ### src/sbd_spi_bridge.sv
// Serial slave with half-bridge enable and status registers.
// Assumes pins are asynchronous and fault inputs are on clk.
`timescale 1ns/1ps
`default_nettype none
`include "sbd_regs.svh"
module sbd_spi_bridge
    import sbd_pkg::*;
#(
    parameter int ADDR_W = `SBD_ADDR_W,
    parameter int DATA_W = `SBD_DATA_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic spi_clk,             // Serial clock pin.
    input wire logic select_low,          // Chip select pin.
    input wire logic mosi,                // Serial data in pin.
    output logic miso,                    // Serial data out.
    output logic miso_oe,                 // High while miso is driven.
    input wire logic [7:0] status_flags,  // Status byte sources.
    input wire logic [7:0] interrupt_status, // Interrupt register.
    input wire logic sleep_mode,          // Sleep or standby entry.
    input wire logic overtemp_evt,        // Over-temperature event.
    input wire logic supply_fault,        // Driver supply out of range.
    input wire logic [4:0] fault_active,  // Failure present.
    input wire logic [4:0] fault_flag,    // Its interrupt flag set.
    input wire logic [7:0] oc_detect,     // Per transistor, odd = high.
    input wire logic [3:0] open_short_flag, // Live diagnostic flags.
    output logic [3:0] high_fet_on,       // High-side gate drive.
    output logic [3:0] low_fet_on         // Low-side gate drive.
);
    // -----------------------------------------------------------------------
    // Parameter check
    // -----------------------------------------------------------------------
    // The command and register layout only fit these widths.
    if (ADDR_W != 5 || DATA_W != 8) begin : g_bad_width
        $error("sbd_spi_bridge supports only 5-bit address, 8-bit data");
    end

    // Pair the two transistor detectors of each driver.
    function automatic logic [3:0] drv_or(input logic [7:0] v);
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            r[i] = v[2*i] | v[2*i+1];
        end
        return r;
    endfunction

    // -----------------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------------
    logic [2:0] sclk_sync_ff; // Bit 0 first stage, bit 2 edge history.
    logic [2:0] cs_sync_ff;   // Same arrangement for chip select.
    logic [1:0] mosi_sync_ff; // Two stages for data in.

    // Idle levels are high for clock and select, so no false edge at reset.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_sync_ff <= 3'h7;
            cs_sync_ff <= 3'h7;
            mosi_sync_ff <= 2'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], spi_clk};
            cs_sync_ff <= {cs_sync_ff[1:0], select_low};
            mosi_sync_ff <= {mosi_sync_ff[0], mosi};
        end
    end

    wire cs_act = ~cs_sync_ff[1];
    wire cs_fall = ~cs_sync_ff[1] & cs_sync_ff[2];
    wire cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];
    wire sclk_rise = cs_act & sclk_sync_ff[1] & ~sclk_sync_ff[2];
    wire sclk_fall = cs_act & ~sclk_sync_ff[1] & sclk_sync_ff[2];
    wire mosi_s = mosi_sync_ff[1];

    // -----------------------------------------------------------------------
    // Frame state
    // -----------------------------------------------------------------------
    sbd_phase_e phase_ff;      // Frame phase.
    logic [4:0] clk_cnt_ff;    // Saturating clock count of the frame.
    logic [2:0] bit_ff;        // Bit position within the byte.
    logic [7:0] rx_ff;         // Receive shifter.
    logic [7:0] cmd_ff;        // Latched command byte.
    logic [4:0] addr_ff;       // Address being read out.
    logic [7:0] tx_ff;         // Transmit shifter.
    logic [4:0] ptr_ff;        // Readback pointer.
    logic [7:0] en_ff;         // Bridge enable register.
    logic [3:0] oc_ff;         // Over-current flags.
    logic miso_ff;
    logic miso_oe_ff;
    logic [3:0] high_ff;
    logic [3:0] low_ff;

    wire [7:0] rx_next = {rx_ff[6:0], mosi_s};
    wire cmd_done = sclk_rise & (phase_ff == PH_CMD) & (bit_ff == 3'h7);
    wire byte_done = sclk_rise & (phase_ff == PH_DATA) & (bit_ff == 3'h7);
    wire is_read = cmd_ff[`SBD_CMD_RW];
    // Bursts only count on reads; the bit means nothing on a write.
    wire burst_rd = is_read & cmd_ff[`SBD_CMD_BURST];
    wire [4:0] cmd_addr = cmd_ff[`SBD_CMD_AHI:`SBD_CMD_ALO];
    wire [4:0] new_addr = rx_next[`SBD_CMD_AHI:`SBD_CMD_ALO];

    // A write commits only on select release after exactly 16 clocks.
    wire wr_ok = ~is_read & (clk_cnt_ff == `SBD_WR_CLOCKS);
    wire commit = cs_rise & (phase_ff != PH_IDLE) & wr_ok;

    // -----------------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------------
    wire w_en = commit & (cmd_addr == `SBD_ADDR_BRIDGE_EN);
    wire w_st = commit & (cmd_addr == `SBD_ADDR_BRIDGE_ST);
    wire w_ptr = commit & (cmd_addr == `SBD_ADDR_PTR);
    wire w_irq = commit & (cmd_addr == `SBD_ADDR_IRQ);
    wire r_en = addr_ff == `SBD_ADDR_BRIDGE_EN;
    wire r_st = addr_ff == `SBD_ADDR_BRIDGE_ST;
    wire r_irq = addr_ff == `SBD_ADDR_IRQ;
    wire r_ptr = addr_ff == `SBD_ADDR_PTR;

    // -----------------------------------------------------------------------
    // Register store
    // -----------------------------------------------------------------------
    sbd_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mem ();

    // Addresses with dedicated logic never land in the store.
    assign mem.wr_en = commit & ~(w_en | w_st | w_ptr | w_irq);
    assign mem.wr_addr = cmd_addr;
    assign mem.wr_data = rx_ff;
    assign mem.rd_addr = addr_ff;

    sbd_reg_store #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_store (
        .clk(clk),
        .arst_n(arst_n),
        .bus(mem.store)
    );

    // -----------------------------------------------------------------------
    // Read data and status byte
    // -----------------------------------------------------------------------
    wire [7:0] status_val = {open_short_flag, oc_ff};
    wire [7:0] slave_status_byte = {status_flags[7:5], |oc_ff,
                      status_flags[3:0]};
    wire [7:0] rd_val = r_en ? en_ff :
                        r_st ? status_val :
                        r_irq ? interrupt_status :
                        r_ptr ? {3'h0, ptr_ff} : mem.rd_data;
    // Command byte carries the status byte, later bytes the read data.
    wire [7:0] tx_load = (phase_ff == PH_CMD) ? slave_status_byte : rd_val;

    // -----------------------------------------------------------------------
    // Frame sequencing
    // -----------------------------------------------------------------------
    // Select high parks everything; the falling edge restarts the frame.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= PH_IDLE;
            clk_cnt_ff <= '0;
            bit_ff <= '0;
        end else if (!cs_act) begin
            phase_ff <= PH_IDLE;
        end else if (cs_fall) begin
            phase_ff <= PH_CMD;
            clk_cnt_ff <= '0;
            bit_ff <= '0;
        end else if (sclk_rise) begin
            bit_ff <= bit_ff + 3'h1;
            // Saturation past 16 marks an overlong write.
            if (clk_cnt_ff != `SBD_CNT_SAT) begin
                clk_cnt_ff <= clk_cnt_ff + 5'h1;
            end
            if (cmd_done) begin
                phase_ff <= PH_DATA;
            end
        end
    end

    // Receive shifter and command capture, sampled on rising edges.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_ff <= '0;
            cmd_ff <= '0;
        end else if (sclk_rise) begin
            rx_ff <= rx_next;
            if (cmd_done) begin
                cmd_ff <= rx_next;
            end
        end
    end

    // Read address: command address on reads, pointer on writes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff <= '0;
        end else if (cmd_done) begin
            addr_ff <= rx_next[`SBD_CMD_RW] ? new_addr : ptr_ff;
        end else if (byte_done && burst_rd) begin
            addr_ff <= addr_ff + 5'h1;
        end
    end
    // Without burst addr_ff holds, so each byte repeats one register.

    // Transmit shifter; the store has several cycles to settle first.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ff <= '0;
            miso_ff <= 1'b0;
        end else if (sclk_fall && bit_ff == 3'h0) begin
            miso_ff <= tx_load[7];
            tx_ff <= {tx_load[6:0], 1'b0};
        end else if (sclk_fall) begin
            miso_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end

    // Drive miso only inside a frame.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            miso_oe_ff <= 1'b0;
        end else begin
            miso_oe_ff <= cs_act;
        end
    end

    // -----------------------------------------------------------------------
    // Bridge registers
    // -----------------------------------------------------------------------
    wire [3:0] oc_hit = drv_or(oc_detect);
    wire gate_all = supply_fault |
                    (|(fault_active & fault_flag));
    logic [7:0] nxt_en;
    logic [3:0] nxt_oc;
    logic [3:0] nxt_high;
    logic [3:0] nxt_low;

    // Safety clears win over any write in the same cycle.
    always_comb begin
        nxt_en = en_ff;
        if (w_en) begin
            nxt_en = rx_ff;
        end
        if (sleep_mode || overtemp_evt) begin
            nxt_en = `SBD_RST_BRIDGE_EN;
        end
    end

    // A new over-current event beats a clear in the same cycle.
    always_comb begin
        nxt_oc = oc_ff;
        if (w_st) begin
            nxt_oc = oc_ff & ~rx_ff[3:0];
        end
        nxt_oc = nxt_oc | oc_hit;
    end

    // Gate drive: one side only, no flag, no global fault.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_high[i] = en_ff[2*i+1] & ~en_ff[2*i]
                          & ~oc_ff[i] & ~gate_all;
            nxt_low[i] = en_ff[2*i] & ~en_ff[2*i+1]
                         & ~oc_ff[i] & ~gate_all;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_ff <= `SBD_RST_BRIDGE_EN;
            oc_ff <= `SBD_RST_BRIDGE_ST;
            ptr_ff <= `SBD_RST_PTR;
            high_ff <= '0;
            low_ff <= '0;
        end else begin
            en_ff <= nxt_en;
            oc_ff <= nxt_oc;
            if (w_ptr) begin
                ptr_ff <= rx_ff[4:0];
            end
            high_ff <= nxt_high;
            low_ff <= nxt_low;
        end
    end

    assign miso = miso_ff;
    assign miso_oe = miso_oe_ff;
    assign high_fet_on = high_ff;
    assign low_fet_on = low_ff;

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_write_commit_en: assert property (
        (w_en && !sleep_mode && !overtemp_evt) |=> en_ff == $past(rx_ff))
        else $error("enable write not committed");
    a_bad_len_drop: assert property (
        (cs_rise && clk_cnt_ff != `SBD_WR_CLOCKS && !sleep_mode
         && !overtemp_evt) |=> $stable(en_ff))
        else $error("write with wrong length changed enables");
    a_hold_mid_frame: assert property (
        (!cs_rise && !sleep_mode && !overtemp_evt) |=> $stable(en_ff))
        else $error("enables changed without select release");
    a_safety_clear: assert property (
        (sleep_mode || overtemp_evt) |=> en_ff == 8'h00)
        else $error("enables not cleared by sleep or overtemp");
    a_no_shoot: assert property (
        (high_fet_on & low_fet_on) == 4'h0)
        else $error("both transistors of a driver on");
    a_oc_blocks: assert property (
        (oc_ff != 4'h0) |=> ((high_fet_on | low_fet_on)
                             & $past(oc_ff)) == 4'h0)
        else $error("flagged driver still on");
    a_gate_off: assert property (
        gate_all |=> (high_fet_on | low_fet_on) == 4'h0)
        else $error("drivers on during gated failure");
    a_oc_set_wins: assert property (
        (oc_hit != 4'h0) |=> (oc_ff & $past(oc_hit)) == $past(oc_hit))
        else $error("over-current event lost");
    a_status_first: assert property (
        (sclk_fall && bit_ff == 3'h0 && phase_ff == PH_CMD)
        |=> miso == $past(slave_status_byte[7]))
        else $error("status byte msb not shifted first");
    a_burst_step: assert property (
        (byte_done && burst_rd) |=> addr_ff == $past(addr_ff) + 5'h1)
        else $error("burst address did not step");
    a_single_hold: assert property (
        (byte_done && !burst_rd) |=> $stable(addr_ff))
        else $error("single read address moved");
    a_idle_quiet: assert property (
        !cs_act |=> !miso_oe)
        else $error("miso driven outside frame");

    c_write_commit: cover property (commit);
    c_burst_read: cover property (byte_done && burst_rd);
    c_long_drop: cover property (cs_rise && clk_cnt_ff == `SBD_CNT_SAT);
endmodule
`default_nettype wire
